// ==== asgoc_top.sv ====
// sample gain and offset correction for four converter sample streams.
// assumes wishbone classic registers and a 14-bit two's complement stream,
// both on the one sample clock; upstream and downstream logic share it.
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module asgoc_top #(
  parameter int BUF_DEPTH = 2
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic                  in_valid_i,
  output logic                       in_ready_o,
  input  wire asgoc_pkg::asgoc_sample_t in_sample_i,
  output logic                       out_valid_o,
  input  wire logic                  out_ready_i,
  output asgoc_pkg::asgoc_sample_t   out_sample_o
);

  localparam int LW = $clog2(BUF_DEPTH + 1);

  logic [15:0]              control_q;
  logic [15:0]              coeff_q [4];
  logic                     sat_flag_q;
  logic [7:0]               count_q;
  logic                     global_gain_enable;
  logic                     global_offset_enable;
  logic                     req;
  logic                     wr_fire;
  logic [5:0]               idx;
  asgoc_pkg::asgoc_sample_t head;
  logic                     head_valid;
  logic                     load;
  logic [LW-1:0]            level;
  logic [15:0]              head_coef;
  logic signed [13:0]       corr_data;
  logic                     corr_sat;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // byte-lane merge of a 16-bit register, shared by the control and coefficient registers
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = wd[7:0];
    end
    if (sel[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // which coefficient register, if any, an index names
  function automatic logic coef_hit(input logic [5:0] i);
    return (i >= asgoc_pkg::IDX_CONV9_EVEN_GAIN_OFS) &&
           (i <= asgoc_pkg::IDX_CONV11_ODD_GAIN_OFS);
  endfunction

  function automatic logic [1:0] coef_slot(input logic [5:0] i);
    logic [5:0] d;
    d = 6'(i - asgoc_pkg::IDX_CONV9_EVEN_GAIN_OFS);
    return d[1:0];
  endfunction

  function automatic logic [4:0] gain_code(input logic [15:0] c);
    return c[asgoc_pkg::GAIN_MSB:asgoc_pkg::GAIN_LSB];
  endfunction

  function automatic logic signed [14:0] offset_value(input logic [15:0] c);
    logic [9:0] o;
    o = c[asgoc_pkg::OFS_MSB:asgoc_pkg::OFS_LSB];
    return $signed({{5{o[9]}}, o});
  endfunction

  // ------------------------------------------------------------------
  // wishbone classic slave
  // ------------------------------------------------------------------
  assign req     = wb_cyc_i && wb_stb_i;
  assign idx     = wb_adr_i[7:2];
  assign wr_fire = req && wb_we_i && wb_ack_o; // write lands on the acked edge

  // one wait state: ack rises the edge after the request, falls after one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
    end
  end

  // read data registered with ack; unmapped words read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_ack_o) begin
      wb_dat_o <= 32'h0000_0000;
      if (idx == asgoc_pkg::IDX_CONTROL3) begin
        wb_dat_o[15:0] <= control_q;
      end else if (coef_hit(idx)) begin
        wb_dat_o[15:0] <= coeff_q[coef_slot(idx)];
      end else if (idx == asgoc_pkg::IDX_STATUS) begin
        wb_dat_o[asgoc_pkg::STAT_SAT_BIT] <= sat_flag_q;
        wb_dat_o[asgoc_pkg::STAT_LVL_LSB +: LW] <= level;
        wb_dat_o[asgoc_pkg::STAT_CNT_LSB +: 8] <= count_q;
      end
    end
  end

  // ------------------------------------------------------------------
  // control and coefficient registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      control_q <= asgoc_pkg::CONTROL_RST;
    end else if (wr_fire && idx == asgoc_pkg::IDX_CONTROL3) begin
      control_q <= merge(control_q, wb_dat_i, wb_sel_i);
    end
  end

  assign global_gain_enable   = control_q[asgoc_pkg::GAIN_EN_BIT];
  assign global_offset_enable = control_q[asgoc_pkg::OFFSET_EN_BIT];

  // reserved bit 10 is stored as written and never used by the datapath
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int k = 0; k < 4; k++) begin
        coeff_q[k] <= asgoc_pkg::COEF_RST;
      end
    end else if (wr_fire && coef_hit(idx)) begin
      coeff_q[coef_slot(idx)] <= merge(coeff_q[coef_slot(idx)], wb_dat_i, wb_sel_i);
    end
  end

  // ------------------------------------------------------------------
  // input buffer: a stalled receiver backs up here, no word is lost
  // ------------------------------------------------------------------
  asgoc_buf #(
    .W     ($bits(asgoc_pkg::asgoc_sample_t)),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (in_valid_i),
    .in_ready_o  (in_ready_o),
    .in_data_i   (in_sample_i),
    .out_valid_o (head_valid),
    .out_ready_i (load),
    .out_data_o  (head),
    .level_o     (level)
  );

  // ------------------------------------------------------------------
  // correction datapath
  // ------------------------------------------------------------------
  // stream tag picks the coefficient: 9e, 10o, 10e, 11o in register order
  assign head_coef = coeff_q[head.stream];

  // offset first, then gain, rounded and clipped to the 14-bit range
  always_comb begin
    logic signed [14:0] diff;
    logic signed [31:0] d32;
    logic signed [31:0] g32;
    logic signed [31:0] acc;
    // defaults first: no path leaves a temporary unassigned
    d32  = '0;
    g32  = '0;
    acc  = '0;
    diff = $signed({head.data[13], head.data});
    if (global_offset_enable) begin
      diff = 15'(diff - offset_value(head_coef));
    end
    d32 = 32'(diff);
    g32 = $signed({16'h0000, asgoc_pkg::GAIN_LUT[gain_code(head_coef)]});
    if (global_gain_enable) begin
      acc = (d32 * g32 + asgoc_pkg::GAIN_ROUND) >>> asgoc_pkg::GAIN_FRAC;
    end else begin
      acc = d32;
    end
    corr_sat = 1'b0;
    if (acc > asgoc_pkg::SAMPLE_MAX) begin
      acc      = asgoc_pkg::SAMPLE_MAX;
      corr_sat = 1'b1;
    end else if (acc < asgoc_pkg::SAMPLE_MIN) begin
      acc      = asgoc_pkg::SAMPLE_MIN;
      corr_sat = 1'b1;
    end
    corr_data = acc[13:0];
  end

  // output register advances whenever it is empty or being drained
  assign load = head_valid && (!out_valid_o || out_ready_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_valid_o  <= 1'b0;
      out_sample_o <= '0;
    end else if (load) begin
      out_valid_o         <= 1'b1;
      out_sample_o.stream <= head.stream;
      out_sample_o.data   <= corr_data;
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // status: sticky clip flag (write one clears, a new clip wins) and count
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sat_flag_q <= 1'b0;
    end else if (load && corr_sat) begin
      sat_flag_q <= 1'b1;
    end else if (wr_fire && idx == asgoc_pkg::IDX_STATUS && wb_sel_i[0] &&
                 wb_dat_i[asgoc_pkg::STAT_SAT_BIT]) begin
      sat_flag_q <= 1'b0;
    end
  end

  // wraps freely; software differences two reads
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= asgoc_pkg::COUNT_RST;
    end else if (load) begin
      count_q <= 8'(count_q + 1'b1);
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  property p_gain_raises;
    @(posedge clk_i) disable iff (rst_i)
    load && global_gain_enable && !global_offset_enable && gain_code(head_coef) != 5'h00
      && head.data == 14'sh1000 |=> out_sample_o.data > 14'sh1000;
  endproperty
  a_gain_raises: assert property (p_gain_raises)
    else $error("enabled nonzero gain did not raise the sample");

  property p_gain_unity;
    @(posedge clk_i) disable iff (rst_i)
    load && global_gain_enable && !global_offset_enable && gain_code(head_coef) == 5'h00
      |=> out_sample_o.data == $past(head.data);
  endproperty
  a_gain_unity: assert property (p_gain_unity)
    else $error("gain code zero changed the sample");

  property p_offset_sub;
    @(posedge clk_i) disable iff (rst_i)
    load && !global_gain_enable && global_offset_enable && !corr_sat
      |=> out_sample_o.data == 14'($past(head.data) - $signed($past(head_coef[9:0])));
  endproperty
  a_offset_sub: assert property (p_offset_sub)
    else $error("offset not subtracted");

  property p_offset_neg;
    @(posedge clk_i) disable iff (rst_i)
    load && !global_gain_enable && global_offset_enable && head_coef[9:0] == 10'h200
      && head.data < 14'sh1000 |=> out_sample_o.data == 14'($past(head.data) + 14'sh0200);
  endproperty
  a_offset_neg: assert property (p_offset_neg)
    else $error("negative offset not applied in 14-bit lsbs");

  property p_reg26;
    @(posedge clk_i) disable iff (rst_i)
    wr_fire && idx == asgoc_pkg::IDX_CONV9_EVEN_GAIN_OFS && wb_sel_i[1:0] == 2'b11
      |=> coeff_q[0] == $past(wb_dat_i[15:0]);
  endproperty
  a_reg26: assert property (p_reg26)
    else $error("conv9_even_gain_offset write not stored");

  property p_reg27;
    @(posedge clk_i) disable iff (rst_i)
    wr_fire && idx == asgoc_pkg::IDX_CONV10_ODD_GAIN_OFS && wb_sel_i[1:0] == 2'b11
      |=> coeff_q[1][15:8] == $past(wb_dat_i[15:8]) && coeff_q[1][7:0] == $past(wb_dat_i[7:0]);
  endproperty
  a_reg27: assert property (p_reg27)
    else $error("conv10_odd_gain_offset write not stored");

  // reads the register directly, not through head_coef, so a wrong
  // stream-to-register index in the datapath is still caught here
  property p_reg28;
    @(posedge clk_i) disable iff (rst_i)
    load && head.stream == asgoc_pkg::STRM_CONV10_EVEN && !global_gain_enable
      && global_offset_enable && !corr_sat
      |=> out_sample_o.data == 14'($past(head.data) - $signed($past(coeff_q[2][9:0])));
  endproperty
  a_reg28: assert property (p_reg28)
    else $error("converter 10 even sample used the wrong register");

  property p_reg29;
    @(posedge clk_i) disable iff (rst_i)
    wr_fire && idx == asgoc_pkg::IDX_CONV11_ODD_GAIN_OFS && wb_sel_i[1:0] == 2'b01
      |=> coeff_q[3][7:0] == $past(wb_dat_i[7:0]) && $stable(coeff_q[3][15:8]);
  endproperty
  a_reg29: assert property (p_reg29)
    else $error("conv11_odd_gain_offset byte write wrong");

  property p_bypass;
    @(posedge clk_i) disable iff (rst_i)
    load && !global_gain_enable && !global_offset_enable
      |=> out_valid_o && out_sample_o.data == $past(head.data)
          && out_sample_o.stream == $past(head.stream);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("disabled correction modified the sample");

endmodule

`default_nettype wire

// ==== asgoc_pkg.sv ====
// package for the sample gain and offset correction block: register map,
// field positions, reset values, gain table and the sample carrier.
// assumes a 14-bit two's complement sample stream and a 32-bit wishbone bus.
package asgoc_pkg;

  // ------------------------------------------------------------------
  // register map (word index; byte address is four times the index)
  // ------------------------------------------------------------------
  localparam logic [5:0] IDX_CONTROL3            = 6'h03;
  localparam logic [5:0] IDX_CONV9_EVEN_GAIN_OFS = 6'h26;
  localparam logic [5:0] IDX_CONV10_ODD_GAIN_OFS = 6'h27;
  localparam logic [5:0] IDX_CONV10_EVN_GAIN_OFS = 6'h28;
  localparam logic [5:0] IDX_CONV11_ODD_GAIN_OFS = 6'h29;
  localparam logic [5:0] IDX_STATUS              = 6'h3f;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int GAIN_EN_BIT   = 12;
  localparam int OFFSET_EN_BIT = 8;
  localparam int GAIN_MSB      = 15;
  localparam int GAIN_LSB      = 11;
  localparam int RSVD_BIT      = 10;
  localparam int OFS_MSB       = 9;
  localparam int OFS_LSB       = 0;
  localparam int STAT_SAT_BIT  = 0;
  localparam int STAT_LVL_LSB  = 4;
  localparam int STAT_CNT_LSB  = 8;

  // ------------------------------------------------------------------
  // reset values and arithmetic constants
  // ------------------------------------------------------------------
  localparam logic [15:0] COEF_RST    = 16'h0000;
  localparam logic [15:0] CONTROL_RST = 16'h0000;
  localparam logic [7:0]  COUNT_RST   = 8'h00;
  localparam int          GAIN_FRAC   = 14;
  localparam logic signed [31:0] GAIN_ROUND = 32'sh0000_2000;
  localparam logic signed [31:0] SAMPLE_MAX = 32'sh0000_1fff;
  localparam logic signed [31:0] SAMPLE_MIN = -32'sh0000_2000;

  // linear gain per 0.2 dB step, unsigned with 14 fraction bits
  localparam logic [15:0] GAIN_LUT [32] = '{
    16'h4000, 16'h417e, 16'h4304, 16'h4494, 16'h462d, 16'h47cf, 16'h497b, 16'h4b32,
    16'h4cf2, 16'h4ebd, 16'h5092, 16'h5273, 16'h545e, 16'h5655, 16'h5858, 16'h5a67,
    16'h5c82, 16'h5eaa, 16'h60de, 16'h6320, 16'h656f, 16'h67cc, 16'h6a37, 16'h6cb0,
    16'h6f38, 16'h71cf, 16'h7476, 16'h772c, 16'h79f3, 16'h7cca, 16'h7fb2, 16'h82ac};

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    STRM_CONV9_EVEN,
    STRM_CONV10_ODD,
    STRM_CONV10_EVEN,
    STRM_CONV11_ODD
  } asgoc_stream_t;

  typedef struct packed {
    asgoc_stream_t      stream;
    logic signed [13:0] data;
  } asgoc_sample_t;

endpackage

// ==== asgoc_buf.sv ====
// two-entry elastic buffer between the converter stream and the correction stage.
// assumes one clock, synchronous active-high reset, valid/ready on both sides.
`timescale 1ns/10ps
`default_nettype none

module asgoc_buf #(
  parameter int W     = 16,
  parameter int DEPTH = 2
) (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         in_valid_i,
  output logic                              in_ready_o,
  input  wire logic [W-1:0]                 in_data_i,
  output logic                              out_valid_o,
  input  wire logic                         out_ready_i,
  output logic [W-1:0]                      out_data_o,
  output logic [$clog2(DEPTH+1)-1:0]        level_o
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int LW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [LW-1:0] count_q;
  logic [LW-1:0] count_d;
  logic          push;
  logic          pop;

  // ------------------------------------------------------------------
  // handshake
  // ------------------------------------------------------------------
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_valid_o = (count_q != '0);
  assign out_data_o  = mem_q[rd_ptr_q];
  assign level_o     = count_q;

  // next occupancy drives the registered ready
  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = LW'(count_q + 1'b1);
    end else if (pop && !push) begin
      count_d = LW'(count_q - 1'b1);
    end
  end

  // ------------------------------------------------------------------
  // storage and pointers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_q   <= '0;
      rd_ptr_q   <= '0;
      count_q    <= '0;
      in_ready_o <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_q <= bump(wr_ptr_q);
      end
      if (pop) begin
        rd_ptr_q <= bump(rd_ptr_q);
      end
      count_q    <= count_d;
      in_ready_o <= (count_d != LW'(DEPTH)); // registered so it never loops back
    end
  end

endmodule

`default_nettype wire

// ==== asgoc_sink.sv ====
// downstream sink model standing for the output serializer path.
// assumes the bench's clock and synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none

module asgoc_sink (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic stall_i,
  input  wire logic valid_i,
  output logic      ready_o
);
  // --------------------------------------------------------------
  // ready follows the stall request one edge late, like a real
  // serializer whose back pressure comes out of a register
  // --------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= !stall_i;
    end
  end
endmodule
`default_nettype wire

// ==== adc_sample_gain_offset_correction_bench.sv ====
// self-checking bench for the gain and offset correction block.
// assumes asgoc_top, the sink model and a 125 MHz clock.
`timescale 1ns/10ps
`default_nettype none

module adc_sample_gain_offset_correction_bench;
  // --------------------------------------------------------------
  // signals and models
  // --------------------------------------------------------------
  localparam int DEPTH = 2;
  logic        clk, rst, cyc, stb, we, ack, in_valid, in_ready;
  logic        out_valid, out_ready, stall, hold, rs_en;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, rng, r;
  logic [15:0] ctrl, coef [4];
  logic [15:0] sq [$];
  logic [31:0] rq [$];
  logic [15:0] modes [3] = '{16'h0100, 16'h1000, 16'h1100};
  int          fails, n_tests, k;
  asgoc_pkg::asgoc_sample_t in_s, out_s;

  asgoc_top #(.BUF_DEPTH(DEPTH)) uut (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .in_valid_i(in_valid),
    .in_ready_o(in_ready), .in_sample_i(in_s), .out_valid_o(out_valid),
    .out_ready_i(out_ready), .out_sample_o(out_s));

  asgoc_sink sink (.clk_i(clk), .rst_i(rst), .stall_i(stall),
    .valid_i(out_valid), .ready_o(out_ready));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  // reference correction: offset first, then gain, then clip
  function automatic logic [15:0] corr(input logic [1:0] s, input logic [13:0] x);
    logic signed [31:0] d, g;
    logic [15:0]        c;
    c = coef[s];
    d = 32'($signed(x));
    g = 32'(asgoc_pkg::GAIN_LUT[c[15:11]]);
    if (ctrl[8]) d = d - 32'($signed(c[9:0]));
    if (ctrl[12]) d = (d * g + 32'sh0000_2000) >>> 14;
    if (d > 32'sh0000_1fff) d = 32'sh0000_1fff;
    if (d < -32'sh0000_2000) d = -32'sh0000_2000;
    return {s, d[13:0]};
  endfunction

  // one classic cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] v,
                     input logic [3:0] m);
    int n;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= m;
    wdat <= {16'h0000, v};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v, input logic [3:0] m);
    bus(1'b1, a, v, m);
    for (int b = 0; b < 2; b++) begin
      if (m[b] && a[7:2] == asgoc_pkg::IDX_CONTROL3) ctrl[b*8 +: 8] = v[b*8 +: 8];
      if (m[b] && a[7:2] >= 6'h26 && a[7:2] <= 6'h29) coef[a[3:2] - 2'h2][b*8 +: 8] = v[b*8 +: 8];
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] v);
    rq.push_back({16'h0000, v});
    bus(1'b0, a, 16'h0000, 4'hf);
  endtask

  task automatic send(input logic [1:0] s, input logic [13:0] x);
    int n;
    in_valid <= 1'b1;
    in_s     <= asgoc_pkg::asgoc_sample_t'({s, x});
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (in_ready !== 1'b1 && n < 200);
    if (n >= 200) fails++;
    sq.push_back(corr(s, x));
  endtask

  task automatic drain();
    int n;
    in_valid <= 1'b0;
    n = 0;
    while (sq.size() != 0 && n < 500) begin
      @(posedge clk);
      n++;
    end
    if (n >= 500) fails++;
    repeat (2) @(posedge clk);
  endtask

  // random words, or full-scale and half-scale (14'h1000) words on every stream when bnd is set
  task automatic burst(input int n, input bit bnd);
    logic [31:0] v;
    for (int i = 0; i < n; i++) begin
      v = xs();
      if (bnd) send(i[1:0], i[3] ? 14'h1000 : (i[2] ? 14'h1fff : 14'h2000));
      else send(v[17:16], v[13:0]);
    end
    drain();
  endtask

  // --------------------------------------------------------------
  // monitors, stall source and watchdog
  // --------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst && out_valid && out_ready) begin
      check({16'h0000, out_s}, {16'h0000, sq.size() != 0 ? sq.pop_front() : 16'hxxxx});
    end
    if (!rst && ack && !we) begin
      check(rdat, rq.size() != 0 ? rq.pop_front() : 32'hxxxx_xxxx);
    end
  end

  // random back pressure keeps the output register standing at times
  always @(posedge clk) stall <= hold | (rs_en & ^xs());

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    stop_test();
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    {cyc, stb, we, in_valid, hold, rs_en} = '0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0000_0000;
    in_s = '0;
    ctrl = 16'h0000;
    coef = '{default: 16'h0000};
    rng = 32'h0000_0063;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h0c, 16'h0000);
    for (int i = 0; i < 4; i++) rd(8'h98 + 8'(4 * i), 16'h0000);
    rd(8'hfc, 16'h0000);
    $display("test reset values done");
    rs_en <= 1'b1;
    burst(16, 1'b0);
    $display("test bypass done");
    for (int i = 0; i < 4; i++) begin
      r = xs();
      wr(8'h98 + 8'(4 * i), r[15:0] & 16'hfbff, 4'h3);
      rd(8'h98 + 8'(4 * i), coef[i]);
    end
    wr(8'h98, coef[0] & 16'h03ff, 4'h2);
    wr(8'ha4, coef[3] | 16'hf800, 4'h2);
    wr(8'h9c, 16'hfbff, 4'h1);
    wr(8'ha0, (coef[2] & 16'hfc00) | 16'h0200, 4'h3);
    wr(8'ha4, 16'h005a, 4'h1);
    rd(8'ha0, coef[2]);
    rd(8'ha4, coef[3]);
    rd(8'h9c, coef[1]);
    $display("test coefficient registers done");
    foreach (modes[i]) begin
      wr(8'h0c, modes[i], 4'h3);
      rd(8'h0c, modes[i]);
      burst(24, 1'b0);
      burst(16, 1'b1);
      $display("test mode %h done", modes[i]);
    end
    hold <= 1'b1;
    repeat (3) @(posedge clk);
    k = 0;
    r = xs();
    in_s <= asgoc_pkg::asgoc_sample_t'(r[15:0]);
    in_valid <= 1'b1;
    repeat (8) begin
      @(posedge clk);
      if (in_ready === 1'b1) begin
        sq.push_back(corr(r[15:14], r[13:0]));
        k++;
        r = xs();
        in_s <= asgoc_pkg::asgoc_sample_t'(r[15:0]);
      end
    end
    in_valid <= 1'b0;
    check(32'(k), 32'(DEPTH + 1));
    hold <= 1'b0;
    drain();
    $display("test full buffer done");
    stop_test();
  end
endmodule
`default_nettype wire
